/* rtl/ppo_defs.svh */
// Offsets, fields, command codes and reset values of the preset block
`ifndef PPO_DEFS_SVH
`define PPO_DEFS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define PPO_IDX_EFF_B1      8'h20
`define PPO_IDX_EFF_B2      8'h21
`define PPO_IDX_EFF_B3      8'h22
`define PPO_IDX_STO_B0      8'h23
`define PPO_IDX_STO_B1      8'h24
`define PPO_IDX_STO_B2      8'h25
`define PPO_IDX_STO_B3      8'h26
`define PPO_IDX_STO_B4      8'h27
`define PPO_IDX_SET_B0      8'h2a
`define PPO_IDX_SET_B1      8'h2b
`define PPO_IDX_SET_B2      8'h2c
`define PPO_IDX_SET_B3      8'h2d
`define PPO_IDX_SET_B4      8'h2e
`define PPO_IDX_PIN_CMD     8'h30
`define PPO_IDX_COMMAND     8'h31
`define PPO_IDX_CONFIG      8'h32
`define PPO_IDX_STATUS      8'h33

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PPO_POS_W           36
`define PPO_CFG_MODE_HI     2
`define PPO_CFG_MT_BIT      3
`define PPO_MODE_PIN_LO     3'h2
`define PPO_MODE_PIN_HI     3'h7

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define PPO_CMD_NONE        8'h00
`define PPO_CMD_WRITE_ALL   8'h01
`define PPO_CMD_WRITE_OFF   8'h02
`define PPO_CMD_ABS_RELOAD  8'h03
`define PPO_CMD_VERN_CHECK  8'h04
`define PPO_CMD_MT_RELOAD   8'h05
`define PPO_CMD_MT_CHECK    8'h06
`define PPO_CMD_SOFT_RST    8'h07
`define PPO_CMD_PRES_RAM    8'h08
`define PPO_CMD_PRES_STORE  8'h09
`define PPO_CMD_BUS_XFER    8'h0a
`define PPO_CMD_EVENT_INC   8'h0b
`define PPO_CMD_FINAL_CFG   8'h0c
`define PPO_CMD_CRC_VERIFY  8'h0d
`define PPO_CMD_CHECKSUM_RECOMPUTE_CMD    8'h0e
`define PPO_CMD_TURN_HIGH   8'h0f
`define PPO_CMD_TURN_LOW    8'h10
`define PPO_CMD_NONE_ALT    8'hff

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PPO_RST_POS         36'h000000000
`define PPO_RST_PIN_CMD     8'h00
`define PPO_RST_MODE        3'h0

`endif

/* rtl/ppo_pkg.sv */
// Types shared by the preset and offset block
package ppo_pkg;

    typedef enum logic [3:0] {
        PPO_RELOAD,
        PPO_IDLE,
        PPO_STOP,
        PPO_CAPTURE,
        PPO_CALC,
        PPO_STORE,
        PPO_EEP,
        PPO_CRC,
        PPO_RESTART
    } ppo_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } ppo_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } ppo_apb_rsp_t;

    typedef struct packed {
        logic [35:0] pos;
        logic        valid;
    } ppo_pos_t;

    typedef struct packed {
        logic       strobe;
        logic [7:0] code;
    } ppo_cmd_t;

    typedef struct packed {
        ppo_state_t   st;
        logic [35:0]  stored;
        logic [35:0]  setpt;
        logic [35:0]  eff;
        logic [35:0]  cap_pos;
        logic [7:0]   pin_cmd;
        logic [2:0]   port_mode;
        logic         mt_cfg;
        logic         store_flag;
        ppo_apb_rsp_t apb;
        ppo_pos_t     pos_out;
        logic         qconv_run;
        logic         eep_wr_req;
        logic         crc_req;
        ppo_cmd_t     cmd;
        logic         pin_en;
    } ppo_regs_t;

endpackage

/* rtl/ppo_pin_sync.sv */
// Preset pin synchroniser and falling-edge pulse
`timescale 1ns/1ps

module ppo_pin_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    input  wire logic pin_n,
    output logic      fall
);

    logic meta;
    logic sync;
    logic last;

    // ------------------------------------------------------------------
    // Two stages, then an edge detector on the settled copy
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 1'b1;
            sync <= 1'b1;
            last <= 1'b1;
            fall <= 1'b0;
        end else if (ce) begin
            meta <= pin_n;
            sync <= meta;
            last <= sync;
            fall <= last & ~sync; // [RQ20]
        end
    end

endmodule

/* rtl/ppo_top.sv */
// Position offset, preset sequence and preset pin command logic
//
// Notes on behaviour
// [RQ1] Preset pin usable only in port modes 2..7
// [RQ2] Pin falling edge runs selected pin command
// [RQ3] Pin codes 00..08 decode, FF none
// [RQ4] Pin codes 09..10 decode further
// [RQ5] Stored offset is the EEPROM configuration offset
// [RQ6] Reload builds effective offset with vernier, multiturn
// [RQ7] Effective offset subtracted at every conversion; here only at conversions while the quadrature converter runs
// [RQ8] Stored offset ignores incremental resolution setting
// [RQ9] Preset makes output position equal setpoint
// [RQ10] Preset starts from command write or pin
// [RQ11] Preset first stops quadrature converter
// [RQ12] Then current position is captured
// [RQ13] New effective, then new stored offset computed
// [RQ14] Only preset-and-store writes offsets to EEPROM
// [RQ15] Preset ends by restarting quadrature converter
// [RQ16] Stored offset byte layout at 0x23..0x27
// [RQ17] Setpoint byte layout at 0x2a..0x2e
// [RQ18] Effective offset bits 35:12 read-only
// [RQ19] Preset requests CRC8 update of offset area
// [RQ20] Pin synchronised, one pulse per falling edge
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "ppo_defs.svh"

module ppo_top
    import ppo_pkg::*;
#(
    parameter int POS_W = `PPO_POS_W
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    input  wire ppo_apb_req_t apb_req,
    output ppo_apb_rsp_t      apb_rsp,
    input  wire logic         preset_pin_n,
    input  wire logic [35:0]  sync_position,
    input  wire logic         conv_valid,
    input  wire logic [35:0]  vernier_data,
    input  wire logic [35:0]  multiturn_data,
    input  wire logic         eep_done,
    output ppo_pos_t          pos_out,
    output logic              qconv_run,
    output logic              eep_wr_req,
    output logic              crc_req,
    output ppo_cmd_t          cmd_out,
    output logic              preset_pin_en
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (POS_W != `PPO_POS_W) begin : g_bad_width
        $error("ppo_top: position width must be 36");
    end

    ppo_regs_t q;
    ppo_regs_t next_q;
    logic      pin_fall;

    // ------------------------------------------------------------------
    // Preset pin front end
    // ------------------------------------------------------------------
    ppo_pin_sync u_pin_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .pin_n   (preset_pin_n),
        .fall    (pin_fall)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic is_preset(input logic [7:0] c);
        is_preset = (c == `PPO_CMD_PRES_RAM) ||
                    (c == `PPO_CMD_PRES_STORE);
    endfunction

    function automatic logic is_reload(input logic [7:0] c);
        is_reload = (c == `PPO_CMD_ABS_RELOAD) ||
                    (c == `PPO_CMD_SOFT_RST);
    endfunction

    // Codes that the pin may fire; anything else is no action
    function automatic logic is_action(input logic [7:0] c);
        is_action = (c != `PPO_CMD_NONE) &&
                    (c != `PPO_CMD_NONE_ALT) &&
                    (c <= `PPO_CMD_TURN_LOW);
    endfunction

    function automatic logic [35:0] amend(input logic [35:0] base,
                                          input logic [35:0] vern,
                                          input logic [35:0] mt,
                                          input logic        use_mt);
        amend = base + vern + (use_mt ? mt : 36'h000000000);
    endfunction

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic [7:0] idx;
    logic       in_range;
    logic       access;
    logic       wr_done;
    logic [7:0] wbyte;

    assign idx      = apb_req.paddr[9:2];
    assign in_range = (apb_req.paddr[11:10] == 2'h0);
    assign access   = apb_req.psel & apb_req.penable;
    assign wr_done  = access & q.apb.pready & apb_req.pwrite;
    assign wbyte    = apb_req.pwdata[7:0];

    logic       mapped;
    logic [7:0] rbyte;

    always_comb begin
        mapped = in_range;
        rbyte  = 8'h00;
        case (idx)
            `PPO_IDX_EFF_B1:  rbyte = q.eff[19:12];           // [RQ18]
            `PPO_IDX_EFF_B2:  rbyte = q.eff[27:20];           // [RQ18]
            `PPO_IDX_EFF_B3:  rbyte = q.eff[35:28];           // [RQ18]
            `PPO_IDX_STO_B0:  rbyte = {q.stored[3:0], 4'h0};  // [RQ16]
            `PPO_IDX_STO_B1:  rbyte = q.stored[11:4];
            `PPO_IDX_STO_B2:  rbyte = q.stored[19:12];
            `PPO_IDX_STO_B3:  rbyte = q.stored[27:20];
            `PPO_IDX_STO_B4:  rbyte = q.stored[35:28];
            `PPO_IDX_SET_B0:  rbyte = {q.setpt[3:0], 4'h0};   // [RQ17]
            `PPO_IDX_SET_B1:  rbyte = q.setpt[11:4];
            `PPO_IDX_SET_B2:  rbyte = q.setpt[19:12];
            `PPO_IDX_SET_B3:  rbyte = q.setpt[27:20];
            `PPO_IDX_SET_B4:  rbyte = q.setpt[35:28];
            `PPO_IDX_PIN_CMD: rbyte = q.pin_cmd;
            `PPO_IDX_COMMAND: rbyte = 8'h00;
            `PPO_IDX_CONFIG:  rbyte = {4'h0, q.mt_cfg, q.port_mode};
            `PPO_IDX_STATUS:  rbyte = {2'h0, q.pin_en, q.qconv_run,
                                       q.st};
            default:          mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Command sources
    // ------------------------------------------------------------------
    logic       sw_cmd;
    logic       pin_cmd_go;
    logic       go;
    logic [7:0] go_code;

    assign sw_cmd     = wr_done & in_range & (idx == `PPO_IDX_COMMAND);
    assign pin_cmd_go = pin_fall & q.pin_en &
                        is_action(q.pin_cmd); // [RQ2] [RQ3] [RQ4]
    // Commands arriving while a sequence runs are dropped
    assign go         = (q.st == PPO_IDLE) & (sw_cmd | pin_cmd_go);
    assign go_code    = sw_cmd ? wbyte : q.pin_cmd;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_q = q;

        // Single-cycle pulses
        next_q.pos_out.valid = 1'b0;
        next_q.eep_wr_req    = 1'b0;
        next_q.crc_req       = 1'b0;
        next_q.cmd.strobe    = 1'b0;

        // APB slave: one wait state, answer registered
        next_q.apb.pready = access & ~q.apb.pready;
        if (access & ~q.apb.pready) begin
            next_q.apb.pslverr = ~mapped;
            next_q.apb.prdata  = (mapped & ~apb_req.pwrite) ?
                                 {24'h000000, rbyte} : 32'h00000000;
        end else begin
            next_q.apb.pslverr = 1'b0;
            next_q.apb.prdata  = 32'h00000000;
        end

        // Software writes of stored offset, setpoint, pin command and configuration
        if (wr_done & in_range) begin
            case (idx)
                `PPO_IDX_STO_B0:  next_q.stored[3:0]   = wbyte[7:4];
                `PPO_IDX_STO_B1:  next_q.stored[11:4]  = wbyte;
                `PPO_IDX_STO_B2:  next_q.stored[19:12] = wbyte;
                `PPO_IDX_STO_B3:  next_q.stored[27:20] = wbyte;
                `PPO_IDX_STO_B4:  next_q.stored[35:28] = wbyte;
                `PPO_IDX_SET_B0:  next_q.setpt[3:0]    = wbyte[7:4];
                `PPO_IDX_SET_B1:  next_q.setpt[11:4]   = wbyte;
                `PPO_IDX_SET_B2:  next_q.setpt[19:12]  = wbyte;
                `PPO_IDX_SET_B3:  next_q.setpt[27:20]  = wbyte;
                `PPO_IDX_SET_B4:  next_q.setpt[35:28]  = wbyte;
                `PPO_IDX_PIN_CMD: next_q.pin_cmd       = wbyte;
                `PPO_IDX_CONFIG: begin
                    next_q.port_mode = wbyte[`PPO_CFG_MODE_HI:0];
                    next_q.mt_cfg    = wbyte[`PPO_CFG_MT_BIT];
                end
                default: ;
            endcase
        end

        // Pin function follows the port mode
        next_q.pin_en = (q.port_mode >= `PPO_MODE_PIN_LO) &&
                        (q.port_mode <= `PPO_MODE_PIN_HI); // [RQ1]

        // Output position, computed on each conversion while the converter runs
        if (conv_valid & q.qconv_run) begin
            next_q.pos_out.pos   = sync_position - q.eff; // [RQ7] [RQ9]
            next_q.pos_out.valid = 1'b1;
        end

        // Hand non-preset commands to the command executor
        if (go & ~is_preset(go_code)) begin
            next_q.cmd.strobe = 1'b1;
            next_q.cmd.code   = go_code;
        end

        // Sequencer
        case (q.st)
            PPO_RELOAD: begin
                // Stored offset is the raw configuration value [RQ5] [RQ8]
                next_q.eff = amend(q.stored, vernier_data,
                                   multiturn_data, q.mt_cfg); // [RQ6]
                next_q.qconv_run = 1'b1;
                next_q.st        = PPO_IDLE;
            end
            PPO_IDLE: begin
                if (go & is_preset(go_code)) begin // [RQ10]
                    next_q.store_flag =
                        (go_code == `PPO_CMD_PRES_STORE);
                    next_q.qconv_run  = 1'b0; // [RQ11]
                    next_q.st         = PPO_STOP;
                end else if (go & is_reload(go_code)) begin
                    next_q.st = PPO_RELOAD; // [RQ6]
                end
            end
            PPO_STOP: begin
                next_q.st = PPO_CAPTURE;
            end
            PPO_CAPTURE: begin
                if (conv_valid) begin
                    next_q.cap_pos = sync_position; // [RQ12]
                    next_q.st      = PPO_CALC;
                end
            end
            PPO_CALC: begin
                next_q.eff = q.cap_pos - q.setpt; // [RQ13] [RQ9]
                next_q.st  = PPO_STORE;
            end
            PPO_STORE: begin
                next_q.stored = q.eff - vernier_data -
                    (q.mt_cfg ? multiturn_data : 36'h000000000); // [RQ13]
                if (q.store_flag) begin
                    next_q.eep_wr_req = 1'b1; // [RQ14]
                    next_q.st         = PPO_EEP;
                end else begin
                    next_q.st = PPO_CRC;
                end
            end
            PPO_EEP: begin
                if (eep_done) begin
                    next_q.st = PPO_CRC;
                end
            end
            PPO_CRC: begin
                next_q.crc_req = 1'b1; // [RQ19]
                next_q.st      = PPO_RESTART;
            end
            PPO_RESTART: begin
                next_q.qconv_run = 1'b1; // [RQ15]
                next_q.st        = PPO_IDLE;
            end
            default: begin
                next_q.st = PPO_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q.st         <= PPO_RELOAD;
            q.stored     <= `PPO_RST_POS;
            q.setpt      <= `PPO_RST_POS;
            q.eff        <= `PPO_RST_POS;
            q.cap_pos    <= `PPO_RST_POS;
            q.pin_cmd    <= `PPO_RST_PIN_CMD;
            q.port_mode  <= `PPO_RST_MODE;
            q.mt_cfg     <= 1'b0;
            q.store_flag <= 1'b0;
            q.apb        <= '0;
            q.pos_out    <= '0;
            q.qconv_run  <= 1'b0;
            q.eep_wr_req <= 1'b0;
            q.crc_req    <= 1'b0;
            q.cmd        <= '0;
            q.pin_en     <= 1'b0;
        end else if (ce) begin
            q <= next_q;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign apb_rsp       = q.apb;
    assign pos_out       = q.pos_out;
    assign qconv_run     = q.qconv_run;
    assign eep_wr_req    = q.eep_wr_req;
    assign crc_req       = q.crc_req;
    assign cmd_out       = q.cmd;
    assign preset_pin_en = q.pin_en;

endmodule

/* test/ppo_top_props.sv */
// Concurrent checks on the ports of the preset and offset block
`timescale 1ns/1ps

module ppo_top_props
    import ppo_pkg::*;
#(
    parameter int POS_W = 36
) (
    input wire logic         pclk,
    input wire logic         presetn,
    input wire logic         ce,
    input wire ppo_apb_req_t apb_req,
    input wire ppo_apb_rsp_t apb_rsp,
    input wire logic         preset_pin_n,
    input wire logic [35:0]  sync_position,
    input wire logic         conv_valid,
    input wire logic [35:0]  vernier_data,
    input wire logic [35:0]  multiturn_data,
    input wire logic         eep_done,
    input wire ppo_pos_t     pos_out,
    input wire logic         qconv_run,
    input wire logic         eep_wr_req,
    input wire logic         crc_req,
    input wire ppo_cmd_t     cmd_out,
    input wire logic         preset_pin_en
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Access phase: one cycle without ready, then ready
    sequence s_one_wait;
        !apb_rsp.pready ##1 apb_rsp.pready;
    endsequence

    // Converter still stopped, then running again shortly
    sequence s_restart;
        !qconv_run ##[1:4] qconv_run;
    endsequence

    chk_wait_state: assert property ($rose(apb_req.penable) |-> s_one_wait)
        else $error("access did not end after one wait state");
    chk_ready_cause: assert property
        (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
        else $error("ready outside an access phase");
    chk_slverr_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("error response without ready");
    chk_rdata_byte: assert property (
        apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h0)
        else $error("read data wider than one byte");
    chk_restart_run: assert property (crc_req |-> s_restart)
        else $error("converter not restarted after checksum request");
    chk_eep_stopped: assert property (
        eep_wr_req |-> !qconv_run ##1 !eep_wr_req)
        else $error("store request while converter runs");
    chk_crc_stopped: assert property (
        crc_req |-> !qconv_run && !eep_wr_req)
        else $error("checksum request out of sequence");
    chk_strobe_pulse: assert property (
        cmd_out.strobe |=> !cmd_out.strobe)
        else $error("command strobe longer than one cycle");
    chk_pos_cause: assert property (
        pos_out.valid |-> $past(conv_valid))
        else $error("position output without conversion");
    chk_valid_stopped: assert property (
        !qconv_run && !$past(qconv_run) |-> !pos_out.valid)
        else $error("position output while converter stopped");
endmodule

bind ppo_top ppo_top_props #(.POS_W(POS_W)) u_ppo_top_props (
    .pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .preset_pin_n(preset_pin_n),
    .sync_position(sync_position), .conv_valid(conv_valid),
    .vernier_data(vernier_data), .multiturn_data(multiturn_data),
    .eep_done(eep_done), .pos_out(pos_out), .qconv_run(qconv_run),
    .eep_wr_req(eep_wr_req), .crc_req(crc_req), .cmd_out(cmd_out),
    .preset_pin_en(preset_pin_en)
);

/* test/ppo_pin_ctl.sv */
// Model of the controller or switch that pulls the preset pin low
`timescale 1ns/1ps

module ppo_pin_ctl (
    input  wire logic pclk,
    output logic      preset_pin_n
);
    // Pull-up holds the pin high between presses
    initial preset_pin_n = 1'b1;

    task automatic press(input int low, input int high);
        @(posedge pclk);
        preset_pin_n <= 1'b0;
        repeat (low) @(posedge pclk);
        preset_pin_n <= 1'b1;
        repeat (high) @(posedge pclk);
    endtask
endmodule

/* test/testbench.sv */
// Self-checking bench of the preset and offset block
`timescale 1ns/1ps
`include "ppo_defs.svh"

module testbench
    import ppo_pkg::*;
;
    typedef struct packed {
        logic [7:0] idx;
        logic [7:0] wd;
        logic [7:0] rd;
        logic       er;
    } ppo_tb_row_t;

    localparam logic [35:0] sp = 36'h785634125;
    localparam logic [35:0] vn = 36'h000001000;
    localparam logic [35:0] mt = 36'h000100000;
    localparam logic [35:0] p1 = 36'h900000000;
    localparam logic [35:0] p2 = 36'h0000abcde;

    logic         pclk = 1'b0;
    logic         presetn, conv_valid, eep_done, e;
    logic         qconv_run, eep_wr_req, crc_req, preset_pin_en;
    logic         preset_pin_n;
    logic [35:0]  sync_position, vernier_data, multiturn_data;
    logic [7:0]   q, last_code, cd;
    logic [39:0]  v;
    ppo_apb_req_t apb_req;
    ppo_apb_rsp_t apb_rsp;
    ppo_pos_t     pos_out;
    ppo_cmd_t     cmd_out;
    int           errors = 0, compares = 0, cycles = 0, k;
    int           n_eep = 0, n_crc = 0, n_stb = 0;
    ppo_tb_row_t  rows [13] = '{
        '{`PPO_IDX_STO_B0, 8'ha5, 8'ha0, 1'b0},
        '{`PPO_IDX_STO_B1, 8'h11, 8'h11, 1'b0},
        '{`PPO_IDX_STO_B2, 8'h22, 8'h22, 1'b0},
        '{`PPO_IDX_STO_B3, 8'h33, 8'h33, 1'b0},
        '{`PPO_IDX_STO_B4, 8'h44, 8'h44, 1'b0},
        '{`PPO_IDX_SET_B0, 8'h5f, 8'h50, 1'b0},
        '{`PPO_IDX_SET_B1, 8'h12, 8'h12, 1'b0},
        '{`PPO_IDX_SET_B2, 8'h34, 8'h34, 1'b0},
        '{`PPO_IDX_SET_B3, 8'h56, 8'h56, 1'b0},
        '{`PPO_IDX_SET_B4, 8'h78, 8'h78, 1'b0},
        '{`PPO_IDX_PIN_CMD, 8'h09, 8'h09, 1'b0},
        '{`PPO_IDX_EFF_B1, 8'hff, 8'h00, 1'b0},
        '{8'h40, 8'hab, 8'h00, 1'b1}
    };

    ppo_top #(.POS_W(36)) u_ppo_top (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .preset_pin_n(preset_pin_n),
        .sync_position(sync_position), .conv_valid(conv_valid),
        .vernier_data(vernier_data), .multiturn_data(multiturn_data),
        .eep_done(eep_done), .pos_out(pos_out), .qconv_run(qconv_run),
        .eep_wr_req(eep_wr_req), .crc_req(crc_req), .cmd_out(cmd_out),
        .preset_pin_en(preset_pin_en)
    );

    ppo_pin_ctl u_ppo_pin_ctl (.pclk(pclk), .preset_pin_n(preset_pin_n));

    always #12.5 pclk = ~pclk;

    always @(posedge pclk) begin
        cycles++;
        if (eep_wr_req === 1'b1) n_eep++;
        if (crc_req === 1'b1) n_crc++;
        if (cmd_out.strobe === 1'b1) begin
            n_stb++;
            last_code = cmd_out.code;
        end
        if (cycles == 20000) begin
            errors++;
            conclude;
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [35:0] got, input logic [35:0] want);
        compares++;
        if (got !== want) begin
            errors++;
            $display("wrong value at %0t: %h not %h", $time, got, want);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        apb_req <= '{1'b1, 1'b0, w, {2'b00, a, 2'b00}, {24'h0, d}};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        if (n == 20) errors++;
        q = apb_rsp.prdata[7:0];
        e = apb_rsp.pslverr;
        apb_req <= '0;
        @(posedge pclk);
    endtask

    // Reads n byte registers from base upward, highest byte first
    task automatic rdv(input logic [7:0] base, input int n);
        v = '0;
        for (int i = n - 1; i >= 0; i--) begin
            apb(1'b0, base + 8'(i), 8'h0);
            v = {v[31:0], q};
        end
    endtask

    task automatic run_wait(input logic lvl);
        int n;
        n = 0;
        while (qconv_run !== lvl && n < 60) begin
            @(posedge pclk);
            n++;
        end
        chk(36'(qconv_run), 36'(lvl));
    endtask

    task automatic conv(input logic [35:0] p, input int n);
        sync_position <= p;
        conv_valid <= 1'b1;
        repeat (n) @(posedge pclk);
        conv_valid <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic preset(input logic [35:0] p, input logic store);
        int n, e0;
        n = 0;
        e0 = n_eep;
        run_wait(1'b0);
        conv(p, 3);
        if (store) begin
            while (n_eep == e0 && n < 60) begin
                @(posedge pclk);
                n++;
            end
            eep_done <= 1'b1;
            @(posedge pclk);
            eep_done <= 1'b0;
        end
        run_wait(1'b1);
        conv(p, 1);
        chk(36'(pos_out.valid), 36'h1);
        chk(pos_out.pos, sp);
    endtask

    task automatic conclude;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        apb_req = '0;
        conv_valid = 1'b0;
        eep_done = 1'b0;
        sync_position = '0;
        vernier_data = '0;
        multiturn_data = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        vernier_data <= vn;
        multiturn_data <= mt;
        @(posedge pclk);
        chk(36'(qconv_run), 36'h1);
        apb(1'b0, `PPO_IDX_PIN_CMD, 8'h0);
        chk(36'(q), 36'h0);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].idx, rows[i].wd);
            chk(36'(e), 36'(rows[i].er));
            apb(1'b0, rows[i].idx, 8'h0);
            chk(36'(q), 36'(rows[i].rd));
            chk(36'(e), 36'(rows[i].er));
        end
        apb(1'b1, `PPO_IDX_COMMAND, `PPO_CMD_PRES_RAM);
        preset(p1, 1'b0);
        chk(36'(n_eep), 36'h0);
        rdv(`PPO_IDX_EFF_B1, 3);
        chk({v[23:0], 12'h0}, (p1 - sp) & ~36'hfff);
        rdv(`PPO_IDX_STO_B0, 5);
        chk(v[39:4], p1 - sp - vn);
        apb(1'b1, `PPO_IDX_CONFIG, 8'h03);
        apb(1'b1, `PPO_IDX_PIN_CMD, `PPO_CMD_PRES_STORE);
        fork
            u_ppo_pin_ctl.press(20, 2);
            preset(p2, 1'b1);
        join
        chk(36'(n_eep), 36'h1);
        chk(36'(n_crc), 36'h2);
        rdv(`PPO_IDX_STO_B0, 5);
        chk(v[39:4], p2 - sp - vn);
        apb(1'b1, `PPO_IDX_PIN_CMD, `PPO_CMD_EVENT_INC);
        for (int m = 0; m < 8; m++) begin
            apb(1'b1, `PPO_IDX_CONFIG, 8'(m));
            k = n_stb;
            u_ppo_pin_ctl.press(2, 8);
            chk(36'(n_stb - k), 36'(m >= 2));
            chk(36'(preset_pin_en), 36'(m >= 2));
        end
        for (int c = 0; c < 18; c++) begin
            cd = (c == 17) ? 8'hff : 8'(c);
            if (cd != 8'h08 && cd != 8'h09) begin
                apb(1'b1, `PPO_IDX_PIN_CMD, cd);
                k = n_stb;
                u_ppo_pin_ctl.press(2, 8);
                chk(36'(n_stb - k),
                    36'(cd >= 8'h01 && cd <= 8'h10));
                if (cd >= 8'h01 && cd <= 8'h10)
                    chk(36'(last_code), 36'(cd));
            end
        end
        rdv(`PPO_IDX_EFF_B1, 3);
        chk({v[23:0], 12'h0}, (p2 - sp) & ~36'hfff);
        apb(1'b1, `PPO_IDX_CONFIG, 8'h0f);
        apb(1'b1, `PPO_IDX_COMMAND, `PPO_CMD_ABS_RELOAD);
        repeat (4) @(posedge pclk);
        rdv(`PPO_IDX_EFF_B1, 3);
        chk({v[23:0], 12'h0}, (p2 - sp + mt) & ~36'hfff);
        conclude;
    end
endmodule
